// ### rtl/ufl_delay_timer.sv
// Millisecond shed trip delay timer with clear on loss of run.
`timescale 1ns/1ps
module ufl_delay_timer #(
    parameter int DW          = ufl_pkg::DLY_W,
    parameter int PSW         = ufl_pkg::PRESC_W,
    parameter int TICK_CYCLES = ufl_pkg::DELAY_UNIT_CYC
) (
    input  wire logic          clock_i,
    input  wire logic          rst_i,
    input  wire logic          ce_i,
    input  wire logic          run_i,
    input  wire logic [DW-1:0] delay_i,
    output logic               expired_o
);
    logic [PSW-1:0] presc_q;
    logic [DW-1:0]  count_q;
    logic           expired_q;

    wire tick    = presc_q == PSW'(TICK_CYCLES - 1);
    wire sat     = &count_q;
    wire expired = run_i && (count_q >= delay_i);

    assign expired_o = expired_q;

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            presc_q   <= '0;
            count_q   <= '0;
            expired_q <= ufl_pkg::FLAG_RESET;
        end
        else if (ce_i)
        begin
            presc_q   <= (!run_i || tick) ? '0 : presc_q + 1'b1;
            count_q   <= !run_i ? '0 : count_q + DW'(tick && !sat);
            expired_q <= expired;
        end
    end
endmodule

// ### rtl/ufl_dir_eval.sv
// Active-power direction decision for the under-frequency load shed unit.
`timescale 1ns/1ps
module ufl_dir_eval #(
    parameter int PW = ufl_pkg::PWR_W,
    parameter int CW = ufl_pkg::CUR_W,
    parameter int TW = ufl_pkg::TAN_W
) (
    input  wire ufl_pkg::ufl_method_type method_i,
    input  wire logic signed [PW-1:0]    power_i,
    input  wire logic signed [PW-1:0]    reactive_i,
    input  wire logic [CW-1:0]           current_i,
    input  wire logic [CW-1:0]           current_min_i,
    input  wire logic signed [PW-1:0]    power_min_i,
    input  wire logic [TW-1:0]           angle_tan_i,
    input  wire logic                    ext_assigned_i,
    input  wire logic                    ext_dir_i,
    input  wire logic                    global_block_i,
    output logic                         block_o
);
    // Internal convention: positive power means the sub-grid exports.
    wire          exporting = !power_i[PW-1] && (power_i != '0);
    wire [PW-1:0] q_mag     = ufl_pkg::ufl_abs(reactive_i);
    wire [PW+TW-1:0] lhs    = (PW+TW)'({q_mag, {ufl_pkg::TAN_FRAC{1'b0}}});
    wire [PW+TW-1:0] rhs    = (PW+TW)'(power_i) * (PW+TW)'(angle_tan_i);
    wire          angle_blk = exporting && (lhs <= rhs);
    wire          power_blk = power_i > power_min_i;
    wire          ext_blk   = ext_assigned_i && ext_dir_i;
    wire          sup_en    = (current_i > current_min_i) && !global_block_i;

    always_comb
    begin
        case (method_i)
            ufl_pkg::UFL_POWER_ANGLE: block_o = sup_en && angle_blk;
            ufl_pkg::UFL_PURE_POWER:  block_o = sup_en && power_blk;
            ufl_pkg::UFL_FREQ_ONLY:   block_o = sup_en && ext_blk;
            default:                  block_o = 1'b0;
        endcase
    end
endmodule

// ### rtl/ufl_pkg.sv
// Shared widths, timing, types and helpers for the under-frequency load shed unit.
package ufl_pkg;
    localparam int FREQ_W = 16;
    localparam int VOLT_W = 16;
    localparam int CUR_W = 16;
    localparam int PWR_W = 24;
    localparam int TAN_W = 16;
    localparam int TAN_FRAC = 8;
    localparam int DLY_W = 16;
    localparam int PRESC_W = 16;
    localparam int CLK_PERIOD_NS = 40;
    localparam int DELAY_UNIT_NS = 1000000;
    localparam int DELAY_UNIT_CYC = DELAY_UNIT_NS / CLK_PERIOD_NS;
    localparam logic FLAG_RESET = 1'b0;

    typedef enum logic [1:0]
    {
        UFL_POWER_ANGLE = 2'h0,
        UFL_PURE_POWER  = 2'h1,
        UFL_FREQ_ONLY   = 2'h3
    } ufl_method_type;

    typedef enum logic [1:0]
    {
        UFL_IDLE  = 2'h0,
        UFL_ALARM = 2'h1,
        UFL_TRIP  = 2'h3
    } ufl_state_type;

    function automatic logic [PWR_W-1:0] ufl_abs(input logic signed [PWR_W-1:0] v);
        ufl_abs = v[PWR_W-1] ? PWR_W'(-v) : PWR_W'(v);
    endfunction
endpackage

// ### rtl/ufl_shed_top.sv
// Under-frequency load shed unit: release, direction block, alarm and delayed trip.
`timescale 1ns/1ps
module ufl_shed_top #(
    parameter int FW          = ufl_pkg::FREQ_W,
    parameter int VW          = ufl_pkg::VOLT_W,
    parameter int CW          = ufl_pkg::CUR_W,
    parameter int PW          = ufl_pkg::PWR_W,
    parameter int TW          = ufl_pkg::TAN_W,
    parameter int DW          = ufl_pkg::DLY_W,
    parameter int TICK_CYCLES = ufl_pkg::DELAY_UNIT_CYC
) (
    input  wire logic                    clock_i,
    input  wire logic                    rst_i,
    input  wire logic                    ce_i,
    input  wire logic [FW-1:0]           freq_i,
    input  wire logic [VW-1:0]           volt_ll_i,
    input  wire logic [CW-1:0]           pos_seq_current_i,
    input  wire logic signed [PW-1:0]    pos_seq_active_power_i,
    input  wire logic signed [PW-1:0]    pos_seq_reactive_power_i,
    input  wire logic                    power_sign_negative_i,
    input  wire ufl_pkg::ufl_method_type direction_method_select_i,
    input  wire logic [TW-1:0]           power_angle_tan_i,
    input  wire logic signed [PW-1:0]    active_power_min_i,
    input  wire logic [CW-1:0]           min_pos_seq_current_i,
    input  wire logic [VW-1:0]           release_voltage_i,
    input  wire logic                    direction_block_i,
    input  wire logic                    external_direction_assigned_i,
    input  wire logic                    external_direction_input_i,
    input  wire logic [FW-1:0]           freq_threshold_i,
    input  wire logic [DW-1:0]           shed_trip_delay_i,
    input  wire logic                    adaptive_activate_i,
    input  wire logic [FW-1:0]           adaptive_freq_threshold_i,
    input  wire logic [DW-1:0]           adaptive_shed_trip_delay_i,
    output logic                         alarm_o,
    output logic                         trip_o,
    output logic                         direction_block_o,
    output logic                         released_o,
    output logic                         underfreq_o
);
    // ======================================================================
    // Input conditioning
    // ======================================================================
    // sign select.
    wire signed [PW-1:0] power_int = power_sign_negative_i
                                     ? PW'(-pos_seq_active_power_i)
                                     : pos_seq_active_power_i;

    wire [FW-1:0] freq_thr = adaptive_activate_i ? adaptive_freq_threshold_i
                                                 : freq_threshold_i;
    wire [DW-1:0] delay_sel = adaptive_activate_i ? adaptive_shed_trip_delay_i
                                                  : shed_trip_delay_i;

    wire under_now = freq_i < freq_thr;
    wire volt_now  = volt_ll_i >= release_voltage_i;
    wire dir_now;

    ufl_dir_eval #(
        .PW (PW),
        .CW (CW),
        .TW (TW)
    ) u_dir (
        .method_i       (direction_method_select_i),
        .power_i        (power_int),
        .reactive_i     (pos_seq_reactive_power_i),
        .current_i      (pos_seq_current_i),
        .current_min_i  (min_pos_seq_current_i),
        .power_min_i    (active_power_min_i),
        .angle_tan_i    (power_angle_tan_i),
        .ext_assigned_i (external_direction_assigned_i),
        .ext_dir_i      (external_direction_input_i),
        .global_block_i (direction_block_i),
        .block_o        (dir_now)
    );

    // ======================================================================
    // Condition stage
    // ======================================================================
    // The conditions are registered first so that the alarm sees one
    // coherent sample of all measurements rather than a mix of two ticks.
    logic under_q;
    logic volt_ok_q;
    logic dir_block_q;

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            under_q     <= ufl_pkg::FLAG_RESET;
            volt_ok_q   <= ufl_pkg::FLAG_RESET;
            dir_block_q <= ufl_pkg::FLAG_RESET;
        end
        else if (ce_i)
        begin
            under_q     <= under_now;
            volt_ok_q   <= volt_now;
            dir_block_q <= dir_now;
        end
    end

    // ======================================================================
    // Alarm and trip sequence
    // ======================================================================
    // alarm on under-frequency when released and not direction-blocked.
    wire alarm_d = under_q && volt_ok_q && !dir_block_q;
    wire expired;

    ufl_pkg::ufl_state_type state_q;
    ufl_pkg::ufl_state_type state_d;
    logic                   alarm_q;
    logic                   trip_q;

    ufl_delay_timer #(
        .DW          (DW),
        .PSW         (ufl_pkg::PRESC_W),
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .clock_i   (clock_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .run_i     (alarm_q),
        .delay_i   (delay_sel),
        .expired_o (expired)
    );

    always_comb
    begin
        case (state_q)
            ufl_pkg::UFL_IDLE:
                state_d = alarm_d ? ufl_pkg::UFL_ALARM : ufl_pkg::UFL_IDLE;
            ufl_pkg::UFL_ALARM:
                if (!alarm_d)
                    state_d = ufl_pkg::UFL_IDLE;
                else if (expired)
                    state_d = ufl_pkg::UFL_TRIP;
                else
                    state_d = ufl_pkg::UFL_ALARM;
            ufl_pkg::UFL_TRIP:
                state_d = alarm_d ? ufl_pkg::UFL_TRIP : ufl_pkg::UFL_IDLE;
            default:
                state_d = ufl_pkg::UFL_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q <= ufl_pkg::UFL_IDLE;
            alarm_q <= ufl_pkg::FLAG_RESET;
            trip_q  <= ufl_pkg::FLAG_RESET;
        end
        else if (ce_i)
        begin
            state_q <= state_d;
            alarm_q <= state_d != ufl_pkg::UFL_IDLE;
            trip_q  <= state_d == ufl_pkg::UFL_TRIP;
        end
    end

    assign alarm_o           = alarm_q;
    assign trip_o            = trip_q;
    assign direction_block_o = dir_block_q;
    assign released_o        = volt_ok_q;
    assign underfreq_o       = under_q;

    // ======================================================================
    // Assertions
    // ======================================================================
    // The alarm_cause_a and block_quiet_a checks skip cycles after a frozen clock
    // enable, since the flops then hold values from an older sample.
    // The threshold compare is a named wire so that its history can be sampled.
    wire power_over = power_int > active_power_min_i;

    alarm_cause_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        $past(ce_i) && alarm_q |-> $past(under_q) && $past(volt_ok_q))
        else $error("Alarm raised without under-frequency and release.");

    block_quiet_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        $past(ce_i) && $past(dir_block_q) |-> !alarm_q && !trip_q)
        else $error("Alarm or trip active during a direction block.");

    volt_gate_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && (volt_ll_i < release_voltage_i) |=> !volt_ok_q)
        else $error("Shedding released below the release voltage.");

    trip_alarm_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        trip_q |-> alarm_q && $past(alarm_q))
        else $error("Trip without a standing alarm.");

    trip_clear_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && alarm_q && !alarm_d |=> !alarm_q && !trip_q)
        else $error("Alarm or trip did not drop with its cause.");

    timer_start_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        $rose(alarm_q) |-> !trip_q ##1 !trip_q)
        else $error("Trip issued without running the delay.");

    global_blk_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && direction_block_i |=> !dir_block_q)
        else $error("Direction evaluated while globally blocked.");

    low_current_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && (pos_seq_current_i <= min_pos_seq_current_i) |=> !dir_block_q)
        else $error("Direction block at low positive-sequence current.");

    freq_only_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && direction_method_select_i == ufl_pkg::UFL_FREQ_ONLY
        && !external_direction_assigned_i |=> !dir_block_q)
        else $error("Frequency-only method blocked by power direction.");

    ext_dir_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && direction_method_select_i == ufl_pkg::UFL_FREQ_ONLY
        && !direction_block_i && (pos_seq_current_i > min_pos_seq_current_i)
        && external_direction_assigned_i |=> dir_block_q == $past(external_direction_input_i))
        else $error("External direction signal not followed.");

    pure_power_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && direction_method_select_i == ufl_pkg::UFL_PURE_POWER
        && !direction_block_i && (pos_seq_current_i > min_pos_seq_current_i)
        |=> dir_block_q == $past(power_over))
        else $error("Active-power threshold block mismatch.");

    adaptive_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && adaptive_activate_i && freq_i < adaptive_freq_threshold_i
        |=> under_q)
        else $error("Adaptive frequency threshold not applied.");

    freeze_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        !ce_i |=> $stable(alarm_q) && $stable(trip_q) && $stable(state_q))
        else $error("State moved while the clock enable was low.");

    cond_freeze_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        !ce_i |=> $stable(under_q) && $stable(volt_ok_q) && $stable(dir_block_q))
        else $error("Condition flops moved while the clock enable was low.");

    volt_alarm_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && !volt_ok_q |=> !alarm_q && !trip_q)
        else $error("Alarm or trip active below the release voltage.");

    under_alarm_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && !under_q |=> !alarm_q && !trip_q)
        else $error("Alarm or trip active without under-frequency.");

    alarm_follow_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && alarm_d |=> alarm_q)
        else $error("Alarm not raised for a released under-frequency.");

    released_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && (volt_ll_i >= release_voltage_i) |=> volt_ok_q)
        else $error("Release missing at or above the release voltage.");

    under_base_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && !adaptive_activate_i && (freq_i < freq_threshold_i) |=> under_q)
        else $error("Normal frequency threshold not applied.");

    over_base_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && !adaptive_activate_i && (freq_i >= freq_threshold_i) |=> !under_q)
        else $error("Under-frequency flagged at or above the threshold.");

    adaptive_over_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && adaptive_activate_i && (freq_i >= adaptive_freq_threshold_i)
        |=> !under_q)
        else $error("Adaptive threshold ignored above its value.");

    consume_angle_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && direction_method_select_i == ufl_pkg::UFL_POWER_ANGLE
        && (power_int <= 0) |=> !dir_block_q)
        else $error("Consuming sub-grid held by the angle method.");

    sign_consume_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && direction_method_select_i == ufl_pkg::UFL_POWER_ANGLE
        && (power_sign_negative_i != pos_seq_active_power_i[PW-1]) |=> !dir_block_q)
        else $error("Sign select not applied before the angle decision.");

    method_none_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && direction_method_select_i == 2'h2 |=> !dir_block_q)
        else $error("Unused method code produced a direction block.");

    trip_expiry_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && alarm_q && alarm_d && expired |=> trip_q)
        else $error("Trip missing after the delay expired.");
endmodule

// ### test/ufl_front_model.sv
// Behavioural measurement front end that feeds the shed unit its measured values.
`timescale 1ns/1ps
module ufl_front_model (
    input  wire logic               clock_i,
    input  wire logic               rst_i,
    input  wire logic               slow_i,
    input  wire logic [15:0]        freq_set_i,
    input  wire logic [15:0]        volt_set_i,
    input  wire logic [15:0]        cur_set_i,
    input  wire logic signed [23:0] pwr_set_i,
    input  wire logic signed [23:0] rpw_set_i,
    output logic [15:0]             freq_o,
    output logic [15:0]             volt_o,
    output logic [15:0]             cur_o,
    output logic signed [23:0]      pwr_o,
    output logic signed [23:0]      rpw_o
);
    logic toggle_q;

    // ========================================
    // Measurement refresh
    // A slow front end refreshes only every second cycle, as a filtered stage would.
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            toggle_q <= 1'b0;
            freq_o   <= 16'h0000;
            volt_o   <= 16'h0000;
            cur_o    <= 16'h0000;
            pwr_o    <= 24'h000000;
            rpw_o    <= 24'h000000;
        end
        else
        begin
            toggle_q <= !toggle_q;
            if (!slow_i || toggle_q)
            begin
                freq_o <= #2 freq_set_i;
                volt_o <= #2 volt_set_i;
                cur_o  <= #2 cur_set_i;
                pwr_o  <= #2 pwr_set_i;
                rpw_o  <= #2 rpw_set_i;
            end
        end
    end
endmodule

// ### test/ufl_shed_top_bench.sv
// Self-checking bench for the under-frequency load shed unit.
`timescale 1ns/1ps
module ufl_shed_top_bench;
    localparam int TICK = 4;
    logic clock_i, rst_i, ce_i, slow, sign_neg, dblk, ext_asg, ext_in, adapt;
    logic [15:0] f_set, v_set, c_set, tan_v, cmin, vrel, fthr, athr, dly, adly;
    logic signed [23:0] p_set, q_set, pmin;
    ufl_pkg::ufl_method_type meth;
    wire [15:0] freq, volt, cur;
    wire signed [23:0] pwr, rpw;
    wire alarm, trip, dir_blk, rel, under;
    int error_cnt, compares, cycles, seed;

    ufl_front_model FRONT (.clock_i(clock_i), .rst_i(rst_i), .slow_i(slow),
        .freq_set_i(f_set), .volt_set_i(v_set), .cur_set_i(c_set), .pwr_set_i(p_set),
        .rpw_set_i(q_set), .freq_o(freq), .volt_o(volt), .cur_o(cur), .pwr_o(pwr), .rpw_o(rpw));

    ufl_shed_top #(.TICK_CYCLES(TICK)) DUT (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
        .freq_i(freq), .volt_ll_i(volt), .pos_seq_current_i(cur),
        .pos_seq_active_power_i(pwr), .pos_seq_reactive_power_i(rpw),
        .power_sign_negative_i(sign_neg), .direction_method_select_i(meth),
        .power_angle_tan_i(tan_v), .active_power_min_i(pmin), .min_pos_seq_current_i(cmin),
        .release_voltage_i(vrel), .direction_block_i(dblk),
        .external_direction_assigned_i(ext_asg), .external_direction_input_i(ext_in),
        .freq_threshold_i(fthr), .shed_trip_delay_i(dly), .adaptive_activate_i(adapt),
        .adaptive_freq_threshold_i(athr), .adaptive_shed_trip_delay_i(adly),
        .alarm_o(alarm), .trip_o(trip), .direction_block_o(dir_blk), .released_o(rel),
        .underfreq_o(under));

    initial
    begin
        clock_i = 1'b0;
        forever #20 clock_i = !clock_i;
    end

    task automatic results();
        $display("Counts: %0d compares, %0d errors", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            results();
        end
    end

    task automatic check(input string name, input logic exp, input logic got);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %0b seen %0b", name, exp, got);
        end
    endtask

    // Direction block worked out from the settled front-end values.
    function automatic logic exp_block();
        longint p, q;
        logic m;
        p = sign_neg ? -longint'(pwr) : longint'(pwr);
        q = (rpw < 0) ? -longint'(rpw) : longint'(rpw);
        case (meth)
            ufl_pkg::UFL_POWER_ANGLE: m = (p > 0) && (q * 256 <= p * longint'(tan_v));
            ufl_pkg::UFL_PURE_POWER: m = p > longint'(pmin);
            ufl_pkg::UFL_FREQ_ONLY: m = ext_asg && ext_in;
            default: m = 1'b0;
        endcase
        return m && !dblk && (cur > cmin);
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #2;
    endtask

    task automatic drive_random();
        int r;
        tick(1);
        r = $random(seed);
        f_set = 16'h1000 | 16'(r[7:0]);
        v_set = 16'h0f00 + 16'(r[16:8]);
        c_set = 16'(r[24:17]);
        adapt = r[25];
        // either arrow convention may be configured
        sign_neg = r[26];
        dblk = r[27] & r[28];
        ext_asg = r[29];
        ext_in = r[30];
        slow = r[31];
        r = $random(seed);
        p_set = {{11{r[12]}}, r[12:0]};
        q_set = {{11{r[25]}}, r[25:13]};
        meth = ufl_pkg::ufl_method_type'(r[27:26]);
        r = $random(seed);
        tan_v = 16'(r[9:0]);
        pmin = {{13{r[20]}}, r[20:10]};
    endtask

    task automatic check_levels();
        tick(4);
        check("underfreq", freq < (adapt ? athr : fthr), under);
        check("released", volt >= vrel, rel);
        check("dir_block", exp_block(), dir_blk);
        check("alarm", (freq < (adapt ? athr : fthr)) && (volt >= vrel) && !exp_block(), alarm);
        check("trip_idle", 1'b0, trip);
    endtask

    task automatic wait_alarm();
        int n;
        n = 0;
        while (alarm !== 1'b1 && n < 20)
        begin
            tick(1);
            n++;
        end
        check("alarm_rise", 1'b1, alarm);
    endtask

    // Trip timing after alarm; abort_at > 0 drops the alarm mid-count first.
    task automatic timed_trip(input logic use_adapt, input logic [15:0] d, input int abort_at);
        int n;
        f_set = 16'h2000;
        v_set = 16'h2000;
        meth = ufl_pkg::UFL_FREQ_ONLY;
        ext_asg = 1'b0;
        dblk = 1'b0;
        slow = 1'b0;
        adapt = use_adapt;
        dly = use_adapt ? d + 16'h0005 : d;
        adly = use_adapt ? d : d + 16'h0005;
        tick(5);
        f_set = 16'h0f00;
        wait_alarm();
        if (abort_at > 0)
        begin
            tick(abort_at);
            f_set = 16'h2000;
            tick(4);
            check("abort_alarm", 1'b0, alarm);
            f_set = 16'h0f00;
            wait_alarm();
        end
        n = 0;
        while (trip !== 1'b1 && n < 1000)
        begin
            tick(1);
            n++;
        end
        check("trip_delay", 1'b1, n >= d * TICK && n <= d * TICK + 4);
    endtask

    initial
    begin
        seed = 32'hcfd49a1f;
        {rst_i, ce_i, slow, sign_neg, dblk, ext_asg, ext_in, adapt} = 8'hc0;
        {f_set, v_set, c_set, tan_v} = 64'h0;
        {p_set, q_set, pmin} = 72'h0;
        cmin = 16'h0080;
        vrel = 16'h1000;
        fthr = 16'h1080;
        athr = 16'h1040;
        dly = 16'd1000;
        adly = 16'd1000;
        meth = ufl_pkg::UFL_FREQ_ONLY;
        repeat (5) @(posedge clock_i);
        #2 rst_i = 1'b0;
        repeat (150)
        begin
            drive_random();
            check_levels();
        end
        timed_trip(1'b0, 16'd0, 0);
        timed_trip(1'b0, 16'd2, 0);
        timed_trip(1'b1, 16'd3, 0);
        timed_trip(1'b0, 16'd3, 8);
        ext_asg = 1'b1;
        ext_in = 1'b1;
        c_set = 16'h0100;
        tick(5);
        check("ext_block_trip", 1'b0, trip || alarm);
        ce_i = 1'b0;
        ext_in = 1'b0;
        tick(6);
        check("ce_hold", 1'b0, alarm);
        ce_i = 1'b1;
        tick(4);
        check("ce_run", 1'b1, alarm);
        rst_i = 1'b1;
        tick(2);
        check("reset_trip", 1'b0, trip || alarm);
        rst_i = 1'b0;
        tick(2);
        results();
    end
endmodule
